// ### include/dio_consts.svh
// constants for the byte-wide digital i/o bank
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

// bank geometry
`define DIO_NUM_PORTS 21
`define DIO_PORT_W 8
`define DIO_SEL_W 5
`define DIO_ADDR_W 8
`define DIO_DATA_W 32

// interrupt sources: low bits of one port
`define DIO_IRQ_PORT 2
`define DIO_IRQ_N 4

// register byte offsets
`define DIO_OFS_ENABLE 8'h00
`define DIO_OFS_PORT_SEL 8'h04
`define DIO_OFS_LATCH 8'h08
`define DIO_OFS_DIR 8'h0C
`define DIO_OFS_INV 8'h10
`define DIO_OFS_IRQ_EN 8'h14
`define DIO_OFS_IRQ_STAT 8'h18

// reset values
`define DIO_RST_ENABLE 1'h0
`define DIO_RST_PORT_SEL 5'h00
`define DIO_RST_LATCH 8'h00
`define DIO_RST_DIR 21'h000000
`define DIO_RST_INV 4'h0
`define DIO_RST_IRQ_EN 1'h0

`endif

// ### include/dio_pkg.sv
// types shared by the digital i/o bank
`default_nettype none
`include "dio_consts.svh"
package dio_pkg;

   // one register-bus request, as seen in one cycle
   typedef struct packed {
      logic [`DIO_ADDR_W-1:0] addr;
      logic [`DIO_DATA_W-1:0] wdata;
      logic we;
      logic re;
   } bus_req_t;

   typedef logic [`DIO_PORT_W-1:0] port_byte_t;

endpackage
`default_nettype wire

// ### logic/dio_port_cell.sv
// one 8-bit bidirectional port: pin synchroniser, output latch, drive control
`timescale 1ns/100ps
`default_nettype none
`include "dio_consts.svh"
module dio_port_cell
   import dio_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // field pins
   input wire port_byte_t pin_in,
   output port_byte_t pin_out,
   output port_byte_t pin_oe_n,
   // control from the register file
   input wire logic latch_we,
   input wire port_byte_t latch_wdata,
   input wire logic dir_out,
   input wire logic io_enable,
   // value software sees for this port
   output port_byte_t port_read_value
);

   port_byte_t meta_q;
   port_byte_t sync_q;
   port_byte_t latch_q;
   port_byte_t oe_n_q;
   logic drive_d;

   // two-flop synchroniser for the asynchronous field levels
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
      end
      else
      begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   // latch takes writes in either direction; an input port just keeps it
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         latch_q <= `DIO_RST_LATCH;
      else if (latch_we)
         latch_q <= latch_wdata;
   end

   // drive only when enabled and set as output; released at reset
   assign drive_d = io_enable & dir_out;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         oe_n_q <= 8'hFF;
      else
         oe_n_q <= {`DIO_PORT_W{~drive_d}};
   end

   assign pin_out = latch_q;

   // read back: pins for an input, latch for an output, zero when disabled
   assign port_read_value = !io_enable ? 8'h00 :
                            dir_out ? latch_q :
                            sync_q;
   assign pin_oe_n = oe_n_q;

endmodule
`default_nettype wire

// ### logic/dio_bank.sv
// digital i/o bank top: register file, port cells, level interrupt
// Summary of operation
// - after reset every port's input and output operation stays disabled
// - after reset every port is an input and drives nothing
// - after reset all latch outputs are released, pins undriven
// - global enable low disables input and output on all ports
// - global enable high allows input and output on all ports
// - an input port reads back its synchronised pin levels
// - an output port reads back its own latch value
// - writing an input port only updates its latch, pins stay undriven
// - switching a port to output drives its held latch value one clock after the direction register takes the write
// - four low bits of port 2 are separate interrupt sources
// - interrupt is level sensitive, high while an adjusted source is high
// - each source has a software inversion select before use
// - requests reach the host only while interrupt enable is set
// - ports are 8 bits wide, each with its own direction bit
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dio_consts.svh"
module dio_bank
   import dio_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // register bus
   input wire bus_req_t bus_req,
   output logic [`DIO_DATA_W-1:0] bus_rdata,
   // field pins, port p on bits p*8 +: 8
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_in,
   output logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_out,
   output logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_oe_n,
   // interrupt to the host, active high level
   output logic irq
);

   //----------------------------------------------------------------
   // register state
   //----------------------------------------------------------------
   logic io_enable_q;
   logic [`DIO_SEL_W-1:0] port_sel_q;
   logic [`DIO_NUM_PORTS-1:0] dir_q;
   logic [`DIO_IRQ_N-1:0] inv_q;
   logic irq_en_q;
   logic irq_q;
   logic [`DIO_DATA_W-1:0] rdata_q;
   logic [`DIO_DATA_W-1:0] rdata_d;
   port_byte_t port_rv [0:`DIO_NUM_PORTS-1];

   //----------------------------------------------------------------
   // address decode
   //----------------------------------------------------------------
   wire hit_enable = (bus_req.addr == `DIO_OFS_ENABLE);
   wire hit_sel = (bus_req.addr == `DIO_OFS_PORT_SEL);
   wire hit_latch = (bus_req.addr == `DIO_OFS_LATCH);
   wire hit_dir = (bus_req.addr == `DIO_OFS_DIR);
   wire hit_inv = (bus_req.addr == `DIO_OFS_INV);
   wire hit_irq_en = (bus_req.addr == `DIO_OFS_IRQ_EN);
   wire hit_stat = (bus_req.addr == `DIO_OFS_IRQ_STAT);
   wire sel_valid = (port_sel_q < 5'(`DIO_NUM_PORTS));
   wire wr_latch = bus_req.we & hit_latch & sel_valid;

   // enable register: the software side of the active-low port reset
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         io_enable_q <= `DIO_RST_ENABLE;
      else if (bus_req.we & hit_enable)
         io_enable_q <= bus_req.wdata[0];
   end

   // port select pointer
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         port_sel_q <= `DIO_RST_PORT_SEL;
      else if (bus_req.we & hit_sel)
         port_sel_q <= bus_req.wdata[`DIO_SEL_W-1:0];
   end

   // one direction bit per port, 1 = output
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         dir_q <= `DIO_RST_DIR;
      else if (bus_req.we & hit_dir)
         dir_q <= bus_req.wdata[`DIO_NUM_PORTS-1:0];
   end

   // inversion select per interrupt source
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         inv_q <= `DIO_RST_INV;
      else if (bus_req.we & hit_inv)
         inv_q <= bus_req.wdata[`DIO_IRQ_N-1:0];
   end

   // interrupt enable
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_en_q <= `DIO_RST_IRQ_EN;
      else if (bus_req.we & hit_irq_en)
         irq_en_q <= bus_req.wdata[0];
   end

   //----------------------------------------------------------------
   // port cells
   //----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < `DIO_NUM_PORTS; p = p + 1)
      begin : g_port
         dio_port_cell u_cell (
            .core_clk(core_clk),
            .resetn(resetn),
            .pin_in(pin_in[p*`DIO_PORT_W +: `DIO_PORT_W]),
            .pin_out(pin_out[p*`DIO_PORT_W +: `DIO_PORT_W]),
            .pin_oe_n(pin_oe_n[p*`DIO_PORT_W +: `DIO_PORT_W]),
            .latch_we(wr_latch & (port_sel_q == 5'(p))),
            .latch_wdata(bus_req.wdata[`DIO_PORT_W-1:0]),
            .dir_out(dir_q[p]),
            .io_enable(io_enable_q),
            .port_read_value(port_rv[p])
         );
      end
   endgenerate

   //----------------------------------------------------------------
   // interrupt sources
   //----------------------------------------------------------------
   // raw levels follow the port's read value, so a disabled bank shows zero
   wire [`DIO_IRQ_N-1:0] irq_source_raw = port_rv[`DIO_IRQ_PORT][`DIO_IRQ_N-1:0];
   wire irq_source_0 = irq_source_raw[0] ^ inv_q[0];
   wire irq_source_1 = irq_source_raw[1] ^ inv_q[1];
   wire irq_source_2 = irq_source_raw[2] ^ inv_q[2];
   wire irq_source_3 = irq_source_raw[3] ^ inv_q[3];
   wire [`DIO_IRQ_N-1:0] irq_adj =
      {irq_source_3, irq_source_2, irq_source_1, irq_source_0} & {`DIO_IRQ_N{io_enable_q}};
   wire irq_d = irq_en_q & (|irq_adj);

   // registered level interrupt, no latching: it follows the sources
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   //----------------------------------------------------------------
   // read path
   //----------------------------------------------------------------
   // selected port value, zero for a pointer beyond the last port
   wire [`DIO_PORT_W-1:0] sel_value = sel_valid ? port_rv[port_sel_q] : 8'h00;

   // read multiplexer; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      if (hit_enable)
         rdata_d[0] = io_enable_q;
      else if (hit_sel)
         rdata_d[`DIO_SEL_W-1:0] = port_sel_q;
      else if (hit_latch)
         rdata_d[`DIO_PORT_W-1:0] = sel_value;
      else if (hit_dir)
         rdata_d[`DIO_NUM_PORTS-1:0] = dir_q;
      else if (hit_inv)
         rdata_d[`DIO_IRQ_N-1:0] = inv_q;
      else if (hit_irq_en)
         rdata_d[0] = irq_en_q;
      else if (hit_stat)
         rdata_d[7:0] = {irq_source_raw, irq_adj};
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rdata_q <= 32'h00000000;
      else if (bus_req.re)
         rdata_q <= rdata_d;
      else
         rdata_q <= 32'h00000000;
   end

   assign bus_rdata = rdata_q;
   assign irq = irq_q;

endmodule
`default_nettype wire

// ### sim/dio_field.sv
// field side of the connector pins: sources and read-back of driven pins
`timescale 1ns/100ps
`default_nettype none
`include "dio_consts.svh"
module dio_field
(
   // levels that the field sources hold on released pins
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] src,
   // device drive
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_out,
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_oe_n,
   // level seen at the device inputs
   output logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_in
);
   // a driven pin shows the device value, a released one the held source level
   assign pin_in = (pin_out & ~pin_oe_n) | (src & pin_oe_n);
endmodule
`default_nettype wire

// ### sim/dio_bank_properties.sv
// concurrent checks on the digital i/o bank ports
`timescale 1ns/100ps
`default_nettype none
`include "dio_consts.svh"
module dio_bank_properties
   import dio_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // bank ports
   input wire bus_req_t bus_req,
   input wire logic [`DIO_DATA_W-1:0] bus_rdata,
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_in,
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_out,
   input wire logic [`DIO_NUM_PORTS*`DIO_PORT_W-1:0] pin_oe_n,
   input wire logic irq
);
   logic en_q;
   logic en_d;
   // writes that may start a port driving
   wire wr_drv = bus_req.we && (bus_req.addr == `DIO_OFS_ENABLE
      || bus_req.addr == `DIO_OFS_DIR);
   // latch reads and interrupt-disable writes
   wire rd_latch = bus_req.re && bus_req.addr == `DIO_OFS_LATCH;
   wire irq_off = bus_req.we && bus_req.addr == `DIO_OFS_IRQ_EN && !bus_req.wdata[0];
   // shadow of the global enable
   assign en_d = (bus_req.we && bus_req.addr == `DIO_OFS_ENABLE) ? bus_req.wdata[0] : en_q;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
         en_q <= 1'b0;
      else
         en_q <= en_d;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // no write and no pin change for three samples
   sequence quiet_s;
      !bus_req.we && $stable(pin_in);
   endsequence
   sequence calm_s;
      quiet_s ##1 quiet_s ##1 quiet_s;
   endsequence
   rdata_idle_a: assert property (!$past(bus_req.re) |-> bus_rdata == 32'h0)
      else $error("read data outside its cycle");
   oe_group_a: assert property (pin_oe_n[31:24] == 8'h00 || pin_oe_n[31:24] == 8'hFF)
      else $error("port enables split");
   oe_start_a: assert property ($fell(pin_oe_n[24]) |-> $past(wr_drv, 2))
      else $error("drive began without a write");
   oe_quiet_a: assert property (&pin_oe_n && !bus_req.we && !$past(bus_req.we) |=> &pin_oe_n)
      else $error("pins driven without a write");
   dis_release_a: assert property (!en_q && !$past(en_q) |-> &pin_oe_n && !irq)
      else $error("disabled bank drives");
   dis_read_a: assert property (rd_latch && !en_q |=> bus_rdata == 32'h0)
      else $error("disabled port read not zero");
   irq_off_a: assert property (irq_off |-> ##2 !irq)
      else $error("interrupt after disable");
   irq_hold_a: assert property (calm_s |=> $stable(irq))
      else $error("interrupt moved without cause");
endmodule
bind dio_bank dio_bank_properties i_props (.core_clk(core_clk), .resetn(resetn),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .irq(irq));
`default_nettype wire

// ### sim/dio_bank_bench.sv
// self-checking bench for the digital i/o bank
`timescale 1ns/100ps
`default_nettype none
`include "dio_consts.svh"
module dio_bank_bench
   import dio_pkg::*;
   ;
   localparam int PW = `DIO_NUM_PORTS*`DIO_PORT_W;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   bus_req_t bus_req = '0;
   logic [31:0] bus_rdata;
   logic [31:0] got;
   logic [PW-1:0] src = '0;
   logic [PW-1:0] pin_in;
   logic [PW-1:0] pin_out;
   logic [PW-1:0] pin_oe_n;
   logic irq;
   int mismatches = 0;
   int cmp_count = 0;
   // ---------------------------------------------------------------
   // clock, design and field
   // ---------------------------------------------------------------
   always #12.5 core_clk = ~core_clk;
   dio_bank i_dut (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
   dio_field i_field (.src(src), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge core_clk);
      bus_req.we <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // read one register and compare the word of the following cycle
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge core_clk);
      bus_req.re <= 1'b0;
      #1 chk(n, e, bus_rdata);
   endtask
   task automatic field(input int p, input logic [7:0] v);
      @(posedge core_clk);
      src[p*8+:8] <= v;
   endtask
   task automatic settle;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      field(3, 8'h5A);
      settle;
      chk("oe_all", 32'h1, {31'h0, &pin_oe_n});
      for (int a = 0; a < 32; a += 4)
         rdc("reset_reg", 8'(a), 32'h0);
      $display("test reset done");
      wr(`DIO_OFS_ENABLE, 32'h1);
      wr(`DIO_OFS_PORT_SEL, 32'h3);
      settle;
      rdc("en_read", `DIO_OFS_ENABLE, 32'h1);
      rdc("sel_read", `DIO_OFS_PORT_SEL, 32'h3);
      rdc("in_read", `DIO_OFS_LATCH, 32'h5A);
      wr(`DIO_OFS_LATCH, 32'hA5);
      settle;
      chk("in_oe", 32'hFF, {24'h0, pin_oe_n[24+:8]});
      rdc("in_keep", `DIO_OFS_LATCH, 32'h5A);
      wr(`DIO_OFS_PORT_SEL, 32'd21);
      wr(`DIO_OFS_LATCH, 32'hFF);
      rdc("sel_over", `DIO_OFS_LATCH, 32'h0);
      wr(`DIO_OFS_PORT_SEL, 32'd20);
      wr(`DIO_OFS_LATCH, 32'h3C);
      wr(`DIO_OFS_PORT_SEL, 32'h3);
      wr(`DIO_OFS_DIR, 32'h8);
      @(posedge core_clk);
      #1 chk("out_oe", 32'h0, {24'h0, pin_oe_n[24+:8]});
      chk("out_pin", 32'hA5, {24'h0, pin_in[24+:8]});
      chk("top_port", 32'h3C, {24'h0, pin_out[160+:8]});
      chk("other_oe", 32'hFF, {24'h0, pin_oe_n[16+:8]});
      rdc("out_read", `DIO_OFS_LATCH, 32'hA5);
      rdc("dir_read", `DIO_OFS_DIR, 32'h8);
      $display("test direction done");
      wr(`DIO_OFS_ENABLE, 32'h0);
      settle;
      chk("off_oe", 32'h1, {31'h0, &pin_oe_n});
      rdc("off_read", `DIO_OFS_LATCH, 32'h0);
      wr(`DIO_OFS_ENABLE, 32'h1);
      settle;
      chk("on_oe", 32'h0, {24'h0, pin_oe_n[24+:8]});
      $display("test enable done");
      wr(`DIO_OFS_INV, 32'h0);
      wr(`DIO_OFS_IRQ_EN, 32'h1);
      rdc("irqen_read", `DIO_OFS_IRQ_EN, 32'h1);
      for (int i = 0; i < `DIO_IRQ_N; i++)
      begin
         field(2, 8'(1 << i));
         settle;
         chk("irq_hi", 32'h1, {31'h0, irq});
         rdc("irq_stat", `DIO_OFS_IRQ_STAT, 32'h11 << i);
         wr(`DIO_OFS_INV, 32'h1 << i);
         settle;
         chk("irq_inv", 32'h0, {31'h0, irq});
         rdc("inv_read", `DIO_OFS_INV, 32'h1 << i);
         field(2, 8'h0);
         settle;
         chk("irq_idle", 32'h1, {31'h0, irq});
         wr(`DIO_OFS_INV, 32'h0);
         settle;
         chk("irq_lo", 32'h0, {31'h0, irq});
      end
      field(2, 8'h1);
      wr(`DIO_OFS_IRQ_EN, 32'h0);
      settle;
      chk("irq_off", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      conclude;
   end
   // cut a hang short well past the expected run of about 200 cycles
   initial
   begin
      repeat (5000) @(posedge core_clk);
      mismatches++;
      conclude;
   end
endmodule
`default_nettype wire
